// ---- rtl/liu_cfg_pkg.sv ----
// register map, field layout and shared types for the line interface register bank
// assumes an 8-bit synchronous host port and eight line channels
// Operation
// - LOS plus enable bit sends all ones
// - global enable inserts system-side ALARM_INDICATION_STATUS on LOS
// - protect-disable bit 0 keeps short protection on
// - global code bit: 0 zero-substitution, 1 AMI
// - depth bit: 0 32-bit store, 1 64-bit
// - placement 01 transmit, 11 receive, else unused
// - channel index selects which template is accessed
// - template code picks one of six pulse shapes; codes 1 and 2 are reserved
// - output-enable bit 1 puts driver high-Z
// - status bit follows detected incoming ALARM_INDICATION_STATUS
// - mask bit 1 allows channel alarm interrupt
// - masked change latches; read clears latch
// - pointer AAH expanded bank, 00H primary
// - single-rail bit 0 follows negative-data pin
// - per-channel code bit picks codec when single-rail is forced by register
// - recovery bit 1 disables channel clock recovery
// - trigger LOS equals reported LOS status; the bank reports no LOS status
package liu_cfg_pkg;

    localparam int NUM_CH = 8;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;

    // primary bank offsets
    localparam logic [ADDR_W-1:0] ADDR_AUTO_ONES   = 8'h0e;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CFG  = 8'h0f;
    localparam logic [ADDR_W-1:0] ADDR_TMPL_INDEX  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_TMPL_SELECT = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_DRIVER_OE   = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_AIS_STATUS  = 8'h13;
    localparam logic [ADDR_W-1:0] ADDR_AIS_MASK    = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_AIS_LATCH   = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_BANK_PTR    = 8'h1f;
    // expanded bank offsets
    localparam logic [ADDR_W-1:0] EADDR_SINGLE_RAIL = 8'h00;
    localparam logic [ADDR_W-1:0] EADDR_LINE_CODE   = 8'h01;
    localparam logic [ADDR_W-1:0] EADDR_CLK_RECOV   = 8'h02;

    localparam logic [DATA_W-1:0] BANK_PRIMARY  = 8'h00;
    localparam logic [DATA_W-1:0] BANK_EXPANDED = 8'haa;
    localparam logic [DATA_W-1:0] RESET_BYTE    = 8'h00;

    // global configuration field positions
    localparam int GCF_AIS_INS   = 6;
    localparam int GCF_SCP_DIS   = 5;
    localparam int GCF_CODE      = 4;
    localparam int GCF_JA_DEPTH  = 3;
    localparam int GCF_JA_BW     = 2;
    localparam int GCF_JA_PLC_HI = 1;
    localparam int GCF_JA_PLC_LO = 0;
    localparam logic [DATA_W-1:0] GCF_DEFINED = 8'h7f;

    localparam int IDX_W  = 3;
    localparam int TMPL_W = 3;

    // jitter placement codes
    localparam logic [1:0] JA_PLC_TX = 2'b01;
    localparam logic [1:0] JA_PLC_RX = 2'b11;

    typedef enum logic [TMPL_W-1:0] {
        TMPL_E1       = 3'h0,
        TMPL_RSVD_A   = 3'h1,
        TMPL_RSVD_B   = 3'h2,
        TMPL_T1_133   = 3'h3,
        TMPL_T1_266   = 3'h4,
        TMPL_T1_399   = 3'h5,
        TMPL_T1_533   = 3'h6,
        TMPL_T1_655   = 3'h7
    } template_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } host_req_t;

    typedef struct packed {
        logic       aisInsertEn;
        logic       shortProtectOn;
        logic       amiGlobal;
        logic       jaDepth64;
        logic       jaBandwidthLow;
        logic       jaInTxPath;
        logic       jaInRxPath;
    } global_ctl_t;

endpackage

// ---- rtl/alarm_irq_latch.sv ----
// per-channel sticky change latch for the incoming alarm status
// assumes status is synchronous to clk; clearRd is a one-cycle read strobe
`timescale 1ns/1ps
module alarm_irq_latch #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] status,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic             clearRd,
    output logic      [WIDTH-1:0] latch
);
    logic [WIDTH-1:0] statusPrev_r;
    logic [WIDTH-1:0] latch_r;
    logic [WIDTH-1:0] latch_nxt;
    logic [WIDTH-1:0] change;

    assign change = (status ^ statusPrev_r) & mask;
    // set wins over the read clear so no edge is lost
    assign latch_nxt = change | (clearRd ? '0 : latch_r);
    assign latch = latch_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            statusPrev_r <= '0;
        else
            statusPrev_r <= status;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            latch_r <= '0;
        else
            latch_r <= latch_nxt;
    end
endmodule

// ---- rtl/liu_config_register_bank.sv ----
// configuration and status registers of the eight-channel line interface
// host port is synchronous: one access per strobe, read data one cycle later
// line-side status inputs are synchronous to clk
`timescale 1ns/1ps
module liu_config_register_bank
    import liu_cfg_pkg::*;
#(
    parameter int CHANNELS = liu_cfg_pkg::NUM_CH
) (
    input  wire logic                                 clk,
    input  wire logic                                 resetn,
    input  wire liu_cfg_pkg::host_req_t               hostReq,
    output logic      [liu_cfg_pkg::DATA_W-1:0]       hostRdData,
    output logic                                      hostRdValid,
    input  wire logic [CHANNELS-1:0]                  losDetect,
    input  wire logic [CHANNELS-1:0]                  aisDetect,
    input  wire logic [CHANNELS-1:0]                  transmitNegativeDataPin,
    output logic      [CHANNELS-1:0]                  txAllOnes,
    output logic      [CHANNELS-1:0]                  sysAisInsert,
    output logic      [CHANNELS-1:0]                  driverHighZ,
    output logic      [CHANNELS-1:0]                  singleRailMode,
    output logic      [CHANNELS-1:0]                  amiCodec,
    output logic      [CHANNELS-1:0]                  clockRecoveryOn,
    output logic      [CHANNELS*liu_cfg_pkg::TMPL_W-1:0] txTemplate,
    output liu_cfg_pkg::global_ctl_t                  globalCtl,
    output logic      [CHANNELS-1:0]                  alarmIrqLatch,
    output logic                                      expandedBank
);
    import liu_cfg_pkg::*;

    logic [CHANNELS-1:0] autoAllOnes_r;
    logic [DATA_W-1:0]   globalCfg_r;
    logic [IDX_W-1:0]    templateIndex_r;
    logic [TMPL_W-1:0]   templateSel_r [CHANNELS];
    logic [CHANNELS-1:0] driverOe_r;
    logic [CHANNELS-1:0] alarmMask_r;
    logic [DATA_W-1:0]   bankPointer_r;
    logic [CHANNELS-1:0] singleRail_r;
    logic [CHANNELS-1:0] lineCode_r;
    logic [CHANNELS-1:0] clockRecovDis_r;
    logic [DATA_W-1:0]   hostRdData_r;
    logic                hostRdValid_r;
    logic [DATA_W-1:0]   rdMux;
    logic                rdLatchClear;
    logic                bankIsExpanded;
    logic [DATA_W-1:0]   rdPrimary;
    logic [DATA_W-1:0]   rdExpanded;
    logic                wrBankPtr;
    logic                wrAutoOnes;
    logic                wrGlobalCfg;
    logic                wrTmplIndex;
    logic                wrTmplSelect;
    logic                wrDriverOe;
    logic                wrAlarmMask;
    logic                wrSingleRail;
    logic                wrLineCode;
    logic                wrClockRecov;

    // decode of one register within its bank
    function automatic logic hits(
        input logic [ADDR_W-1:0] addr,
        input logic              expanded,
        input logic [ADDR_W-1:0] target,
        input logic              targetExpanded
    );
        hits = (addr == target) && (expanded == targetExpanded);
    endfunction

    // widen a channel vector onto the data bus
    function automatic logic [DATA_W-1:0] toByte(input logic [CHANNELS-1:0] v);
        logic [DATA_W-1:0] b;
        b = '0;
        for (int i = 0; i < CHANNELS && i < DATA_W; i++)
        begin
            b[i] = v[i];
        end
        return b;
    endfunction

    // take the low channel bits of a written byte
    function automatic logic [CHANNELS-1:0] fromByte(input logic [DATA_W-1:0] b);
        logic [CHANNELS-1:0] v;
        v = '0;
        for (int i = 0; i < CHANNELS && i < DATA_W; i++)
        begin
            v[i] = b[i];
        end
        return v;
    endfunction

    // placement codes 00 and 10 leave the attenuator out of both paths
    function automatic global_ctl_t decodeGlobal(input logic [DATA_W-1:0] cfg);
        global_ctl_t g;
        g.aisInsertEn    = cfg[GCF_AIS_INS];
        g.shortProtectOn = !cfg[GCF_SCP_DIS];
        g.amiGlobal      = cfg[GCF_CODE];
        g.jaDepth64      = cfg[GCF_JA_DEPTH];
        g.jaBandwidthLow = cfg[GCF_JA_BW];
        g.jaInTxPath     = cfg[GCF_JA_PLC_HI:GCF_JA_PLC_LO] == JA_PLC_TX;
        g.jaInRxPath     = cfg[GCF_JA_PLC_HI:GCF_JA_PLC_LO] == JA_PLC_RX;
        return g;
    endfunction

    // pointer value other than the expanded key keeps the primary map
    assign bankIsExpanded = (bankPointer_r == BANK_EXPANDED);
    assign expandedBank   = bankIsExpanded;

    // status and latch offsets get no strobe, so writes there fall away
    assign wrBankPtr    = hostReq.wr && (hostReq.addr == ADDR_BANK_PTR);
    assign wrAutoOnes   = hostReq.wr && hits(hostReq.addr, bankIsExpanded, ADDR_AUTO_ONES, 1'b0);
    assign wrGlobalCfg  = hostReq.wr && hits(hostReq.addr, bankIsExpanded, ADDR_GLOBAL_CFG, 1'b0);
    assign wrTmplIndex  = hostReq.wr && hits(hostReq.addr, bankIsExpanded, ADDR_TMPL_INDEX, 1'b0);
    assign wrTmplSelect = hostReq.wr && hits(hostReq.addr, bankIsExpanded, ADDR_TMPL_SELECT, 1'b0);
    assign wrDriverOe   = hostReq.wr && hits(hostReq.addr, bankIsExpanded, ADDR_DRIVER_OE, 1'b0);
    assign wrAlarmMask  = hostReq.wr && hits(hostReq.addr, bankIsExpanded, ADDR_AIS_MASK, 1'b0);
    assign wrSingleRail = hostReq.wr && hits(hostReq.addr, bankIsExpanded, EADDR_SINGLE_RAIL, 1'b1);
    assign wrLineCode   = hostReq.wr && hits(hostReq.addr, bankIsExpanded, EADDR_LINE_CODE, 1'b1);
    assign wrClockRecov = hostReq.wr && hits(hostReq.addr, bankIsExpanded, EADDR_CLK_RECOV, 1'b1);

    // bank pointer is visible in both banks so software can always get back
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bankPointer_r <= BANK_PRIMARY;
        end
        else if (wrBankPtr)
        begin
            bankPointer_r <= hostReq.data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            autoAllOnes_r <= '0;
        end
        else if (wrAutoOnes)
        begin
            autoAllOnes_r <= fromByte(hostReq.data);
        end
    end

    // reserved top bit is not stored and reads as zero
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            globalCfg_r <= RESET_BYTE;
        end
        else if (wrGlobalCfg)
        begin
            globalCfg_r <= hostReq.data & GCF_DEFINED;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            templateIndex_r <= '0;
        end
        else if (wrTmplIndex)
        begin
            templateIndex_r <= hostReq.data[IDX_W-1:0];
        end
    end

    // one template slot per channel, written through the shared index
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : gTemplate
            always_ff @(posedge clk)
            begin
                if (!resetn)
                begin
                    templateSel_r[ch] <= TMPL_E1;
                end
                else if (wrTmplSelect && templateIndex_r == IDX_W'(ch))
                begin
                    templateSel_r[ch] <= hostReq.data[TMPL_W-1:0];
                end
            end
            assign txTemplate[ch*TMPL_W +: TMPL_W] = templateSel_r[ch];
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            driverOe_r <= '0;
        end
        else if (wrDriverOe)
        begin
            driverOe_r <= fromByte(hostReq.data);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            alarmMask_r <= '0;
        end
        else if (wrAlarmMask)
        begin
            alarmMask_r <= fromByte(hostReq.data);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            singleRail_r <= '0;
        end
        else if (wrSingleRail)
        begin
            singleRail_r <= fromByte(hostReq.data);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            lineCode_r <= '0;
        end
        else if (wrLineCode)
        begin
            lineCode_r <= fromByte(hostReq.data);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            clockRecovDis_r <= '0;
        end
        else if (wrClockRecov)
        begin
            clockRecovDis_r <= fromByte(hostReq.data);
        end
    end

    // status and latch registers have no write path at all
    // read clears the change latch in the same cycle the data is captured
    assign rdLatchClear = hostReq.rd && hits(hostReq.addr, bankIsExpanded, ADDR_AIS_LATCH, 1'b0);

    alarm_irq_latch #(
        .WIDTH   (CHANNELS)
    ) uAlarmLatch (
        .clk     (clk),
        .resetn  (resetn),
        .status  (aisDetect),
        .mask    (alarmMask_r),
        .clearRd (rdLatchClear),
        .latch   (alarmIrqLatch)
    );

    always_comb
    begin
        rdPrimary = '0;
        case (hostReq.addr)
            ADDR_AUTO_ONES:   rdPrimary = toByte(autoAllOnes_r);
            ADDR_GLOBAL_CFG:  rdPrimary = globalCfg_r;
            ADDR_TMPL_INDEX:  rdPrimary = DATA_W'(templateIndex_r);
            ADDR_TMPL_SELECT: rdPrimary = DATA_W'(templateSel_r[templateIndex_r]);
            ADDR_DRIVER_OE:   rdPrimary = toByte(driverOe_r);
            ADDR_AIS_STATUS:  rdPrimary = toByte(aisDetect);
            ADDR_AIS_MASK:    rdPrimary = toByte(alarmMask_r);
            ADDR_AIS_LATCH:   rdPrimary = toByte(alarmIrqLatch);
            default:          rdPrimary = '0;
        endcase
    end

    always_comb
    begin
        rdExpanded = '0;
        case (hostReq.addr)
            EADDR_SINGLE_RAIL: rdExpanded = toByte(singleRail_r);
            EADDR_LINE_CODE:   rdExpanded = toByte(lineCode_r);
            EADDR_CLK_RECOV:   rdExpanded = toByte(clockRecovDis_r);
            default:           rdExpanded = '0;
        endcase
    end

    // pointer answers in both banks; unmapped offsets read zero
    always_comb
    begin
        if (hostReq.addr == ADDR_BANK_PTR)
            rdMux = bankPointer_r;
        else if (bankIsExpanded)
            rdMux = rdExpanded;
        else
            rdMux = rdPrimary;
    end

    // read data held until the next read so a slow host may sample late
    always_ff @(posedge clk)
    begin
        if (!resetn)
            hostRdData_r <= '0;
        else if (hostReq.rd)
            hostRdData_r <= rdMux;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            hostRdValid_r <= 1'b0;
        else
            hostRdValid_r <= hostReq.rd;
    end

    assign hostRdData  = hostRdData_r;
    assign hostRdValid = hostRdValid_r;

    // global controls decoded from the configuration byte
    assign globalCtl = decodeGlobal(globalCfg_r);

    // per-channel datapath steering, each bit independent of its neighbours
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : gChannel
            logic forcedSingle;
            // the forcing only holds while clock recovery is running
            assign forcedSingle = singleRail_r[ch] && !clockRecovDis_r[ch];
            // the same LOS input feeds both actions; no LOS status register is kept
            assign txAllOnes[ch]    = autoAllOnes_r[ch] && losDetect[ch];
            assign sysAisInsert[ch] = globalCtl.aisInsertEn && losDetect[ch];
            assign driverHighZ[ch]  = driverOe_r[ch];
            assign singleRailMode[ch] = singleRail_r[ch] ? forcedSingle
                                                         : transmitNegativeDataPin[ch];
            // per-channel code only counts in forced single rail, else global
            assign amiCodec[ch] = forcedSingle ? lineCode_r[ch]
                                               : globalCtl.amiGlobal;
            assign clockRecoveryOn[ch] = !clockRecovDis_r[ch];
        end
    endgenerate

endmodule

// ---- test/liu_config_register_bank_checker.sv ----
// port assertions for the line interface register bank
// bound into every bank instance; sees its ports only
`timescale 1ns/1ps
module liu_config_register_bank_checker
#(
    parameter int CHANNELS = 8
) (
    input wire logic                     clk,
    input wire logic                     resetn,
    input wire liu_cfg_pkg::host_req_t   hostReq,
    input wire logic                     hostRdValid,
    input wire logic [CHANNELS-1:0]      losDetect,
    input wire logic [CHANNELS-1:0]      aisDetect,
    input wire logic [CHANNELS-1:0]      txAllOnes,
    input wire logic [CHANNELS-1:0]      sysAisInsert,
    input wire liu_cfg_pkg::global_ctl_t globalCtl,
    input wire logic [CHANNELS-1:0]      alarmIrqLatch,
    input wire logic                     expandedBank
);
    import liu_cfg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic ptrWr = hostReq.wr && hostReq.addr == ADDR_BANK_PTR;

    AST_ALL_ONES: assert property ((txAllOnes & ~losDetect) == '0)
        else $error("all ones sent without loss of signal");
    AST_AIS_INS: assert property (sysAisInsert == ({CHANNELS{globalCtl.aisInsertEn}} & losDetect))
        else $error("system alarm insertion wrong");
    AST_JA_PLACE: assert property (hostReq.wr && hostReq.addr == ADDR_GLOBAL_CFG && !expandedBank
        |=> !(globalCtl.jaInTxPath && globalCtl.jaInRxPath)
        && globalCtl.jaInTxPath == ($past(hostReq.data[GCF_JA_PLC_HI:GCF_JA_PLC_LO]) == JA_PLC_TX)
        && globalCtl.jaInRxPath == ($past(hostReq.data[GCF_JA_PLC_HI:GCF_JA_PLC_LO]) == JA_PLC_RX))
        else $error("attenuator placement wrong");
    AST_RD_VALID: assert property (hostReq.rd |=> hostRdValid)
        else $error("read answer missing");
    AST_RD_PULSE: assert property (!hostReq.rd |=> !hostRdValid)
        else $error("read valid without read");
    AST_BANK_EXP: assert property (ptrWr && hostReq.data == BANK_EXPANDED |=> expandedBank)
        else $error("expanded bank not selected");
    AST_BANK_PRI: assert property (ptrWr && hostReq.data != BANK_EXPANDED |=> !expandedBank)
        else $error("primary bank not selected");
    AST_RESET: assert property ($rose(resetn) |-> !hostRdValid && alarmIrqLatch == '0)
        else $error("reset state wrong");
    AST_LATCH_CLR: assert property (hostReq.rd && hostReq.addr == ADDR_AIS_LATCH && !expandedBank
        && $stable(aisDetect) && $past(resetn) |=> alarmIrqLatch == '0)
        else $error("latch not cleared by read");
    AST_LATCH_SET: assert property ((alarmIrqLatch & ~$past(alarmIrqLatch)) != '0 && $past(resetn, 2)
        |-> $past(aisDetect) != $past(aisDetect, 2))
        else $error("latch set without change");

    COV_LATCH_RD: cover property (hostReq.rd && hostReq.addr == ADDR_AIS_LATCH && alarmIrqLatch != '0);
    COV_BANK: cover property (expandedBank ##1 !expandedBank);
    COV_ONES: cover property (txAllOnes != '0);
endmodule
bind liu_config_register_bank liu_config_register_bank_checker #(.CHANNELS(CHANNELS)) CHECK (.clk, .resetn,
    .hostReq, .hostRdValid, .losDetect, .aisDetect, .txAllOnes, .sysAisInsert, .globalCtl, .alarmIrqLatch,
    .expandedBank);

// ---- test/host_port_model.sv ----
// host processor model for the register port
// one access at a time; strobes move just after a rising edge
`timescale 1ns/1ps
module host_port_model
(
    input  wire logic                             clk,
    input  wire logic [liu_cfg_pkg::DATA_W-1:0]   rdData,
    input  wire logic                             rdValid,
    output liu_cfg_pkg::host_req_t                req
);
    import liu_cfg_pkg::*;
    initial req = '0;
    // released address and data show inverted values, never stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, data: ~req.data};
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~req.data};
        d = rdValid === 1'b1 ? rdData : 8'hxx;
    endtask
endmodule

// ---- test/liu_config_register_bank_tb_top.sv ----
// self-checking bench for the line interface register bank
// host model drives the port; line status inputs are driven here
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module liu_config_register_bank_tb_top;
    import liu_cfg_pkg::*;
    logic        clk, resetn, hostRdValid, expandedBank;
    host_req_t   hostReq;
    global_ctl_t globalCtl;
    logic [7:0]  hostRdData, losDetect, aisDetect, pin, txAllOnes, sysAisInsert, driverHighZ;
    logic [7:0]  singleRailMode, amiCodec, clockRecoveryOn, alarmIrqLatch, d;
    logic [23:0] txTemplate;
    int          fail_count = 0;
    int          total_checks = 0;

    liu_config_register_bank DUT (.clk(clk), .resetn(resetn), .hostReq(hostReq), .hostRdData(hostRdData),
        .hostRdValid(hostRdValid), .losDetect(losDetect), .aisDetect(aisDetect),
        .transmitNegativeDataPin(pin), .txAllOnes(txAllOnes), .sysAisInsert(sysAisInsert),
        .driverHighZ(driverHighZ), .singleRailMode(singleRailMode), .amiCodec(amiCodec),
        .clockRecoveryOn(clockRecoveryOn), .txTemplate(txTemplate), .globalCtl(globalCtl),
        .alarmIrqLatch(alarmIrqLatch), .expandedBank(expandedBank));
    host_port_model HOST (.clk(clk), .rdData(hostRdData), .rdValid(hostRdValid), .req(hostReq));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_defaults();
        logic [7:0] a [9] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h1f, 8'h20};
        foreach (a[i])
        begin
            HOST.rd(a[i], d);
            `CHK(d, RESET_BYTE)
        end
        `CHK(globalCtl, 7'h20)
        `CHK(clockRecoveryOn, 8'hff)
        `CHK(expandedBank, 1'b0)
    endtask

    task automatic t_all_ones();
        HOST.wr(ADDR_AUTO_ONES, 8'h5a);
        losDetect = 8'h3c;
        step(1);
        `CHK(txAllOnes, 8'h18)
        `CHK(sysAisInsert, 8'h00)
        HOST.wr(ADDR_GLOBAL_CFG, 8'h40);
        `CHK(sysAisInsert, 8'h3c)
        losDetect = 8'h00;
        step(1);
        `CHK(txAllOnes, 8'h00)
    endtask

    task automatic t_global();
        logic [7:0] w [3] = '{8'h3d, 8'h03, 8'h02};
        logic [6:0] e [3] = '{7'h1e, 7'h21, 7'h20};
        foreach (w[i])
        begin
            HOST.wr(ADDR_GLOBAL_CFG, w[i]);
            `CHK(globalCtl, e[i])
            HOST.rd(ADDR_GLOBAL_CFG, d);
            `CHK(d, w[i])
        end
        HOST.wr(ADDR_GLOBAL_CFG, 8'h08);
        `CHK(globalCtl.jaDepth64, 1'b1)
    endtask

    task automatic t_template();
        for (int ch = 0; ch < 8; ch++)
        begin
            HOST.wr(ADDR_TMPL_INDEX, 8'(ch));
            HOST.wr(ADDR_TMPL_SELECT, 8'(7 - ch));
        end
        for (int ch = 0; ch < 8; ch++)
        begin
            `CHK(txTemplate[3*ch +: 3], 3'(7 - ch))
            HOST.wr(ADDR_TMPL_INDEX, 8'(ch));
            HOST.rd(ADDR_TMPL_SELECT, d);
            `CHK(d, 8'(7 - ch))
        end
        HOST.wr(ADDR_DRIVER_OE, 8'ha5);
        `CHK(driverHighZ, 8'ha5)
    endtask

    task automatic t_alarm();
        HOST.wr(ADDR_AIS_MASK, 8'h0f);
        aisDetect = 8'h11;
        step(2);
        `CHK(alarmIrqLatch, 8'h01)
        HOST.rd(ADDR_AIS_STATUS, d);
        `CHK(d, 8'h11)
        HOST.rd(ADDR_AIS_LATCH, d);
        `CHK(d, 8'h01)
        `CHK(alarmIrqLatch, 8'h00)
        HOST.wr(ADDR_AIS_LATCH, 8'hff);
        HOST.rd(ADDR_AIS_LATCH, d);
        `CHK(d, 8'h00)
        aisDetect = 8'h00;
        step(2);
        `CHK(alarmIrqLatch, 8'h01)
    endtask

    task automatic t_bank();
        HOST.wr(ADDR_BANK_PTR, BANK_EXPANDED);
        `CHK(expandedBank, 1'b1)
        HOST.wr(EADDR_SINGLE_RAIL, 8'hf0);
        HOST.wr(EADDR_LINE_CODE, 8'h30);
        HOST.wr(EADDR_CLK_RECOV, 8'h50);
        HOST.wr(ADDR_AUTO_ONES, 8'hff);
        pin = 8'h0f;
        step(1);
        `CHK(singleRailMode, 8'haf)
        `CHK(amiCodec, 8'h20)
        `CHK(clockRecoveryOn, 8'haf)
        HOST.rd(EADDR_SINGLE_RAIL, d);
        `CHK(d, 8'hf0)
        HOST.wr(ADDR_BANK_PTR, BANK_PRIMARY);
        `CHK(expandedBank, 1'b0)
        HOST.rd(ADDR_AUTO_ONES, d);
        `CHK(d, 8'h5a)
        pin = 8'hf0;
        step(1);
        `CHK(singleRailMode, 8'ha0)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #100us;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        resetn = 1'b0;
        losDetect = 8'h00;
        aisDetect = 8'h00;
        pin = 8'h00;
        step(10);
        resetn = 1'b1;
        t_defaults();
        t_all_ones();
        t_global();
        t_template();
        t_alarm();
        t_bank();
        print_verdict();
    end
endmodule
